// [fbp_flash.sv]
`timescale 1ns/1ps
module fbp_flash (
   // clock and reset
   input  wire logic                          clk_sys_i,
   input  wire logic                          reset_n_i,
   // protection marking, two bits per region
   input  wire logic [2*fbp_pkg::REGIONS-1:0] prot_i,
   // read port
   input  wire fbp_pkg::fbp_rd_req_s          rd_req_i,
   output logic [31:0]                        rd_data_o,
   output logic                               rd_valid_o,
   output logic                               rd_refused_o,
   // modify port
   input  wire fbp_pkg::fbp_mod_req_s         mod_req_i,
   output logic                               mod_done_o,
   output logic                               mod_refused_o
);

   ////////////////////////////////////////////////////////////////////////////
   // protection decode

   // region of a word address, used by both ports
   function automatic fbp_pkg::fbp_prot_e region_prot(
      input logic [fbp_pkg::ADDR_W-1:0]     addr,
      input logic [2*fbp_pkg::REGIONS-1:0]  prot
   );
      logic [fbp_pkg::REGION_W-1:0] r;
      r = addr[fbp_pkg::ADDR_W-1 -: fbp_pkg::REGION_W];
      return fbp_pkg::fbp_prot_e'(prot[2*r +: 2]);
   endfunction

   logic rd_ok;
   logic mod_ok;
   fbp_pkg::fbp_prot_e rd_prot;
   fbp_pkg::fbp_prot_e mod_prot;

   // read permission: fetch always, data and debugger only outside execute-only
   always_comb begin
      rd_prot = region_prot(rd_req_i.addr, prot_i);
      case (rd_prot)
         fbp_pkg::FBP_PROT_XO: begin
            rd_ok = (rd_req_i.src == fbp_pkg::FBP_SRC_FETCH);
         end
         fbp_pkg::FBP_PROT_RO: begin
            rd_ok = 1'b1;
         end
         default: begin
            rd_ok = 1'b1;
         end
      endcase
   end

   // modify permission: only an unmarked region takes erase or program;
   // the unused marking code counts as locked, the safer reading of it
   always_comb begin
      mod_prot = region_prot(mod_req_i.addr, prot_i);
      case (mod_prot)
         fbp_pkg::FBP_PROT_OPEN: begin
            mod_ok = 1'b1;
         end
         fbp_pkg::FBP_PROT_RO: begin
            mod_ok = 1'b0;
         end
         default: begin
            mod_ok = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // array storage, one generate slice per erase unit

   // erase unit of a word address, used by both ports
   function automatic logic [fbp_pkg::UNIT_W-1:0] unit_of(
      input logic [fbp_pkg::ADDR_W-1:0] addr
   );
      return addr[fbp_pkg::ADDR_W-1 -: fbp_pkg::UNIT_W];
   endfunction

   // read-back of every unit and the shared modify strobes
   logic [31:0] unit_rd [fbp_pkg::UNITS];
   logic        erase_hit;
   logic        prog_hit;

   // strobes already carry the permission, so a refused request touches nothing
   always_comb begin
      erase_hit = mod_ok && (mod_req_i.cmd == fbp_pkg::FBP_CMD_ERASE);
      prog_hit  = mod_ok && (mod_req_i.cmd == fbp_pkg::FBP_CMD_PROGRAM);
   end

   for (genvar u = 0; u < fbp_pkg::UNITS; u++) begin : g_unit
      logic [31:0] word_q [fbp_pkg::UNIT_WORDS];
      logic [31:0] word_d [fbp_pkg::UNIT_WORDS];
      logic        unit_hit;

      // only the named unit reacts, its neighbours keep their words
      assign unit_hit = (unit_of(mod_req_i.addr) == fbp_pkg::UNIT_W'(u));

      // erase fills the whole unit; program clears bits of one word, as a real cell would
      always_comb begin
         for (int w = 0; w < fbp_pkg::UNIT_WORDS; w++) begin
            word_d[w] = word_q[w];
            if (erase_hit && unit_hit) begin
               word_d[w] = fbp_pkg::ERASED_WORD;
            end else if (prog_hit && unit_hit &&
                         mod_req_i.addr[fbp_pkg::OFS_W-1:0] == w[fbp_pkg::OFS_W-1:0]) begin
               word_d[w] = word_q[w] & mod_req_i.data;
            end
         end
      end

      // unit comes up erased; refused requests leave it alone
      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            for (int w = 0; w < fbp_pkg::UNIT_WORDS; w++) begin
               word_q[w] <= fbp_pkg::ERASED_WORD;
            end
         end else begin
            for (int w = 0; w < fbp_pkg::UNIT_WORDS; w++) begin
               word_q[w] <= word_d[w];
            end
         end
      end

      // word of this unit at the read offset, chosen by unit further down
      assign unit_rd[u] = word_q[rd_req_i.addr[fbp_pkg::OFS_W-1:0]];
   end

   ////////////////////////////////////////////////////////////////////////////
   // answers, one cycle after the request

   logic [31:0] rd_data_q;
   logic [31:0] rd_data_d;
   logic        rd_valid_q;
   logic        rd_valid_d;
   logic        rd_ref_q;
   logic        rd_ref_d;
   logic        mod_done_q;
   logic        mod_done_d;
   logic        mod_ref_q;
   logic        mod_ref_d;

   // limitations worth knowing:
   // erase and program finish in the cycle they are taken, no busy phase
   // a read in the same cycle as a modify of that word sees the old contents
   // both ports accept a new request on every clock, no back-pressure
   // the unused command code is answered like a command but changes nothing

   // refused reads return zero so protected code never leaks
   always_comb begin
      rd_valid_d = 1'b0;
      rd_ref_d   = 1'b0;
      rd_data_d  = 32'h00000000;
      if (rd_req_i.valid) begin
         if (rd_ok) begin
            rd_valid_d = 1'b1;
            rd_data_d  = unit_rd[unit_of(rd_req_i.addr)];
         end else begin
            rd_ref_d   = 1'b1;
         end
      end
   end

   // read answer stands one cycle, then falls back to idle zeros
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_data_q  <= 32'h00000000;
         rd_valid_q <= 1'b0;
         rd_ref_q   <= 1'b0;
      end else begin
         rd_data_q  <= rd_data_d;
         rd_valid_q <= rd_valid_d;
         rd_ref_q   <= rd_ref_d;
      end
   end

   // any command code other than FBP_CMD_NONE counts, so the requester always gets an answer
   always_comb begin
      mod_done_d = 1'b0;
      mod_ref_d  = 1'b0;
      if (mod_req_i.cmd != fbp_pkg::FBP_CMD_NONE) begin
         if (mod_ok) begin
            mod_done_d = 1'b1;
         end else begin
            mod_ref_d  = 1'b1;
         end
      end
   end

   // modify answer, one cycle pulse
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mod_done_q <= 1'b0;
         mod_ref_q  <= 1'b0;
      end else begin
         mod_done_q <= mod_done_d;
         mod_ref_q  <= mod_ref_d;
      end
   end

   assign rd_data_o     = rd_data_q;
   assign rd_valid_o    = rd_valid_q;
   assign rd_refused_o  = rd_ref_q;
   assign mod_done_o    = mod_done_q;
   assign mod_refused_o = mod_ref_q;

endmodule

// [fbp_pkg.sv]
package fbp_pkg;

   // array geometry
   localparam int ARRAY_BYTES = 16384;
   localparam int UNIT_BYTES  = 1024;
   localparam int REGION_UNITS = 2;
   localparam int WORD_BYTES  = 4;
   localparam int WORDS       = ARRAY_BYTES / WORD_BYTES;
   localparam int UNIT_WORDS  = UNIT_BYTES / WORD_BYTES;
   localparam int UNITS       = ARRAY_BYTES / UNIT_BYTES;
   localparam int REGIONS     = UNITS / REGION_UNITS;
   localparam int ADDR_W      = 12;
   localparam int UNIT_W      = 4;
   localparam int OFS_W       = 8;
   localparam int REGION_W    = 3;

   // erased state of every cell
   localparam logic [31:0] ERASED_WORD = 32'hffffffff;

   // per-region protection marking
   typedef enum logic [1:0] {
      FBP_PROT_OPEN = 2'b00,
      FBP_PROT_RO   = 2'b01,
      FBP_PROT_XO   = 2'b10
   } fbp_prot_e;

   // read source
   typedef enum logic [1:0] {
      FBP_SRC_FETCH = 2'b00,
      FBP_SRC_DATA  = 2'b01,
      FBP_SRC_DEBUG = 2'b10
   } fbp_src_e;

   // modify command
   typedef enum logic [1:0] {
      FBP_CMD_NONE    = 2'b00,
      FBP_CMD_PROGRAM = 2'b01,
      FBP_CMD_ERASE   = 2'b10
   } fbp_cmd_e;

   // read request
   typedef struct packed {
      logic                valid;
      fbp_src_e            src;
      logic [ADDR_W-1:0]   addr;
   } fbp_rd_req_s;

   // modify request
   typedef struct packed {
      fbp_cmd_e            cmd;
      logic [ADDR_W-1:0]   addr;
      logic [31:0]         data;
   } fbp_mod_req_s;

endpackage

// [fbp_asserts.sv]
`timescale 1ns/1ps
module fbp_asserts (
   // watched ports
   input logic                  clk_sys_i,
   input logic                  reset_n_i,
   input logic [15:0]           prot_i,
   input fbp_pkg::fbp_rd_req_s  rd_req_i,
   input logic [31:0]           rd_data_o,
   input logic                  rd_valid_o,
   input logic                  rd_refused_o,
   input fbp_pkg::fbp_mod_req_s mod_req_i,
   input logic                  mod_done_o,
   input logic                  mod_refused_o
);
   // marking of the region each request aims at
   wire [1:0] rp = prot_i[{rd_req_i.addr[11:9], 1'b0} +: 2];
   wire [1:0] mp = prot_i[{mod_req_i.addr[11:9], 1'b0} +: 2];
   wire       mv = mod_req_i.cmd != 2'h0;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   property p_ans; rd_req_i.valid |=> rd_valid_o != rd_refused_o; endproperty
   a_ans: assert property (p_ans) else $error("read unanswered");
   property p_xo; rd_req_i.valid && rd_req_i.src != 2'h0 && rp == 2'h2 |=> rd_refused_o && !rd_data_o; endproperty
   a_xo: assert property (p_xo) else $error("data read served");
   property p_rd; rd_req_i.valid && rp == 2'h0 |=> rd_valid_o; endproperty
   a_rd: assert property (p_rd) else $error("open read refused");
   property p_lock; mv && mp != 2'h0 |=> mod_refused_o && !mod_done_o; endproperty
   a_lock: assert property (p_lock) else $error("locked modify done");
   property p_mod; mv && mp == 2'h0 |=> mod_done_o && !mod_refused_o; endproperty
   a_mod: assert property (p_mod) else $error("open modify refused");
   property p_fetch; rd_req_i.valid && rd_req_i.src == 2'h0 |=> rd_valid_o && !rd_refused_o; endproperty
   a_fetch: assert property (p_fetch) else $error("fetch refused");
   property p_idle; !rd_req_i.valid |=> !rd_valid_o && !rd_refused_o && rd_data_o == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("read answer without request");
   cover property (rd_refused_o);
   cover property (mod_refused_o);
   cover property (mod_done_o && rd_valid_o);
endmodule
bind fbp_flash fbp_asserts fbp_asserts_i (.*);

// [fbp_host.sv]
`timescale 1ns/1ps
module fbp_host (
   // clock and request lines
   input  logic                  clk_sys_i,
   output fbp_pkg::fbp_rd_req_s  rd_req_o,
   output fbp_pkg::fbp_mod_req_s mod_req_o
);
   // one request cycle; released lines carry inverted values so stale data never matches
   task automatic go(input fbp_pkg::fbp_rd_req_s r, input fbp_pkg::fbp_mod_req_s m);
      @(posedge clk_sys_i);
      rd_req_o <= r;
      mod_req_o <= m;
      @(posedge clk_sys_i);
      rd_req_o <= {1'b0, ~r[13:0]};
      mod_req_o <= {2'h0, ~m[43:0]};
   endtask
   // idle lines from time zero
   initial begin
      rd_req_o = '0;
      mod_req_o = '0;
   end
endmodule

// [tb.sv]
`timescale 1ns/1ps
module tb;
   logic                  clk_sys_i, reset_n_i, rd_valid_o, rd_refused_o, mod_done_o, mod_refused_o;
   logic [15:0]           prot_i;
   logic [31:0]           rd_data_o;
   fbp_pkg::fbp_rd_req_s  rd_req_i;
   fbp_pkg::fbp_mod_req_s mod_req_i;
   int                    fail_count = 0;
   int                    num_checks = 0;
   fbp_host fbp_host_i (.clk_sys_i(clk_sys_i), .rd_req_o(rd_req_i), .mod_req_o(mod_req_i));
   fbp_flash fbp_flash_i (.*);
   ////////////////////////////////////////////////////////////
   // 20 MHz clock
   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // flags nibble is read ok, read refused, modify done, modify refused
   task automatic op(input logic [14:0] r, input logic [45:0] m, input logic [35:0] e);
      fbp_host_i.go(r, m);
      #1 chk({rd_valid_o, rd_refused_o, mod_done_o, mod_refused_o, rd_data_o}, e);
   endtask
   ////////////////////////////////////////////////////////////
   // same-cycle reads see the old word, so each line checks one step behind
   task automatic s_open;
      op(15'h4005, '0, 36'h8ffffffff);
      op(15'h5005, {2'h1, 12'h005, 32'h12345678}, 36'haffffffff);
      op(15'h6005, {2'h1, 12'h105, 32'h0}, 36'ha12345678);
      op(15'h4105, {2'h2, 12'h0ff, 32'h0}, 36'ha00000000);
      op(15'h5005, '0, 36'h8ffffffff);
      op(15'h4105, '0, 36'h800000000);
   endtask
   // region 1 read-only, region 2 execute-only, region 3 open
   task automatic s_prot;
      op('0, {2'h1, 12'h405, 32'ha5a5a5a5}, 36'h200000000);
      @(posedge clk_sys_i) prot_i <= 16'h0024;
      op(15'h5205, {2'h1, 12'h205, 32'h0}, 36'h9ffffffff);
      op(15'h5405, {2'h2, 12'h400, 32'h0}, 36'h500000000);
      op(15'h6405, {2'h2, 12'h300, 32'h0}, 36'h500000000);
      op(15'h4405, {2'h1, 12'h605, 32'h0}, 36'haa5a5a5a5);
      op(15'h5205, '0, 36'h8ffffffff);
   endtask
   // reset, then the scenarios
   initial begin
      reset_n_i = 1'b0;
      prot_i = '0;
      repeat (12) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      s_open;
      s_prot;
      test_done;
   end
   // hang guard, several times the expected run
   initial begin
      repeat (300) @(posedge clk_sys_i);
      fail_count++;
      test_done;
   end
endmodule
